/* usbep_pkg.sv */
// Package for the endpoint-0 control, frame number and selector registers.
// Assumes a 32-bit Avalon-MM slave port reached with word-aligned byte addresses.
package usbep_pkg;
	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_FRAME_LOW = 32'h44a00170;
	localparam logic [31:0] ADDR_FRAME_HIGH = 32'h44a00174;
	localparam logic [31:0] ADDR_SELECTOR = 32'h44a00178;
	localparam logic [31:0] ADDR_EP0_STATUS = 32'h44a00184;
	localparam logic [31:0] ADDR_EP_PENDING = 32'h44a001fc;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int BIT_ACK_EARLY = 7;
	localparam int BIT_ACK_RX = 6;
	localparam int BIT_FORCE_STALL = 5;
	localparam int BIT_EARLY_END = 4;
	localparam int BIT_LAST_DATA = 3;
	localparam int BIT_STALL_SENT = 2;
	localparam int BIT_TX_LOADED = 1;
	localparam int BIT_RX_WAITING = 0;
	localparam int BIT_EP0_PENDING = 0;
	localparam int FRAME_BITS = 11;
	localparam logic [7:0] EP0_INDEX = 8'h00;

	// Events reported by the USB link logic, one-cycle pulses
	typedef struct packed {
		logic sof_valid;
		logic [10:0] sof_frame;
		logic rx_packet_done;
		logic tx_packet_sent;
		logic protocol_stall;
		logic early_end;
		logic transfer_done;
	} usbep_link_s;

	// Endpoint-0 state offered back to the link logic
	typedef struct packed {
		logic force_stall;
		logic tx_loaded;
		logic rx_waiting;
		logic last_data;
		logic fifo_flush;
		logic fifo_blocked;
	} usbep_ctrl_s;
endpackage

/* usbep_regs.sv */
// Endpoint-0 control/status, frame number capture and endpoint selector.
// Assumes link events are synchronous one-cycle pulses on clk from the USB logic.
// ------------------------------------------------------------
// Summary of operation
// (R1) Start-of-frame number is loaded into low and high frame bytes.
// (R2) Frame byte registers are read-only, bits 7..0, reset to zero.
// (R3) Writable eight-bit selector picks which endpoint's indexed registers are reached.
// (R4) Endpoint-0 status shares first IN status location, reached with selector zero.
// (R5) Writing one to bit 7 clears the early-end flag.
// (R6) Writing one to bit 6 clears the received-packet flag.
// (R7) Force-stall bit 5 stalls the control transfer while set.
// (R8) Early-end flag bit 4 sets when transfer ends before last-data set.
// (R9) Early end flushes the endpoint-0 FIFO and blocks processor FIFO access.
// (R10) Processor sets last-data bit 3; device clears it at transfer end.
// (R11) Stall-sent bit 2 set on protocol violation; cleared by writing zero.
// (R12) Transmit-loaded bit 1 set by processor, cleared by device after delivery.
// (R13) Received-packet bit 0 set once a valid packet lands in the FIFO.
// (R14) Endpoint-0 events set the endpoint-0 pending bit 0.
// (R15) Frame bytes update together; unused high bits read as zero.
// ------------------------------------------------------------
`timescale 1ns/1ps
module usbep_regs (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire usbep_pkg::usbep_link_s link,
	output usbep_pkg::usbep_ctrl_s ctrl,
	output logic [7:0] endpoint_index,
	output logic ep0_pending
);
	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] frame_count_low;
	logic [7:0] frame_count_high;
	logic [7:0] endpoint_selector;
	logic force_stall;
	logic early_end;
	logic last_data;
	logic stall_sent;
	logic tx_loaded;
	logic rx_waiting;
	logic pending;
	logic flush_pulse;
	logic answered;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// One wait cycle, then the answer at the second edge
	wire req = avs_read | avs_write;
	wire take = req & answered;
	wire wr = avs_write & take & avs_byteenable[0];
	wire sel_low = avs_address == usbep_pkg::ADDR_FRAME_LOW;
	wire sel_high = avs_address == usbep_pkg::ADDR_FRAME_HIGH;
	wire sel_index = avs_address == usbep_pkg::ADDR_SELECTOR;
	wire sel_csr = avs_address == usbep_pkg::ADDR_EP0_STATUS;
	wire sel_pend = avs_address == usbep_pkg::ADDR_EP_PENDING;
	wire ep0_sel = endpoint_selector == usbep_pkg::EP0_INDEX; // see (R4)
	wire wr_csr = wr & sel_csr & ep0_sel; // see (R4)
	wire wr_index = wr & sel_index; // see (R3)
	wire wr_pend = wr & sel_pend;
	wire [7:0] wd = avs_writedata[7:0];
	wire [7:0] csr_view = {2'b00, force_stall, early_end, last_data, stall_sent, tx_loaded,
		rx_waiting};
	wire [7:0] rd_byte = sel_low ? frame_count_low :
		sel_high ? frame_count_high :
		sel_index ? endpoint_selector :
		(sel_csr & ep0_sel) ? csr_view :
		sel_pend ? {7'h00, pending} : 8'h00;

	// Event terms
	wire early_evt = link.early_end & ~last_data; // see (R8)
	wire last_clr = link.transfer_done & last_data; // see (R10)
	wire tx_clr_evt = link.tx_packet_sent & tx_loaded; // see (R12)
	wire any_evt = link.rx_packet_done | tx_clr_evt | link.protocol_stall | early_evt
		| last_clr; // see (R14)

	assign avs_waitrequest = req & ~answered;
	assign ctrl = '{force_stall: force_stall, tx_loaded: tx_loaded, rx_waiting: rx_waiting,
		last_data: last_data, fifo_flush: flush_pulse, fifo_blocked: early_end};
	assign endpoint_index = endpoint_selector;
	assign ep0_pending = pending;

	// Bus answer timing and read data
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			answered <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			answered <= req & ~answered;
			if (avs_read & ~answered)
				avs_readdata <= {24'h000000, rd_byte};
		end
	end

	// Frame number capture, both bytes in one edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			frame_count_low <= usbep_pkg::RST_BYTE; // see (R2)
			frame_count_high <= usbep_pkg::RST_BYTE; // see (R2)
		end else if (link.sof_valid) begin
			frame_count_low <= link.sof_frame[7:0]; // see (R1)
			frame_count_high <= {5'b00000, link.sof_frame[10:8]}; // see (R15)
		end
	end

	// Endpoint selector
	always_ff @(posedge clk) begin
		if (sys_rst)
			endpoint_selector <= usbep_pkg::RST_BYTE;
		else if (wr_index)
			endpoint_selector <= wd; // see (R3)
	end

	// Endpoint-0 flags; hardware sets win over software clears
	// FIFO flush strobe, one cycle after an early end
	always_ff @(posedge clk) begin
		if (sys_rst)
			flush_pulse <= 1'b0;
		else
			flush_pulse <= early_evt; // see (R9)
	end

	// Force-stall, written as a plain value
	always_ff @(posedge clk) begin
		if (sys_rst)
			force_stall <= 1'b0;
		else if (wr_csr)
			force_stall <= wd[usbep_pkg::BIT_FORCE_STALL]; // see (R7)
	end

	// Early-end flag; a new event beats the acknowledge
	always_ff @(posedge clk) begin
		if (sys_rst)
			early_end <= 1'b0;
		else if (early_evt)
			early_end <= 1'b1; // see (R8)
		else if (wr_csr & wd[usbep_pkg::BIT_ACK_EARLY])
			early_end <= 1'b0; // see (R5)
	end

	// Last-data flag; the processor's set beats the device clear
	always_ff @(posedge clk) begin
		if (sys_rst)
			last_data <= 1'b0;
		else if (wr_csr & wd[usbep_pkg::BIT_LAST_DATA])
			last_data <= 1'b1; // see (R10)
		else if (link.transfer_done)
			last_data <= 1'b0; // see (R10)
	end

	// Stall-sent flag; writing zero clears, writing one keeps it
	always_ff @(posedge clk) begin
		if (sys_rst)
			stall_sent <= 1'b0;
		else if (link.protocol_stall)
			stall_sent <= 1'b1; // see (R11)
		else if (wr_csr & ~wd[usbep_pkg::BIT_STALL_SENT])
			stall_sent <= 1'b0; // see (R11)
	end

	// Transmit-loaded flag; a stall also drops a loaded packet
	always_ff @(posedge clk) begin
		if (sys_rst)
			tx_loaded <= 1'b0;
		else if (wr_csr & wd[usbep_pkg::BIT_TX_LOADED])
			tx_loaded <= 1'b1; // see (R12)
		else if (link.tx_packet_sent | link.protocol_stall)
			tx_loaded <= 1'b0; // see (R12)
	end

	// Received-packet flag; only the acknowledge bit clears it
	always_ff @(posedge clk) begin
		if (sys_rst)
			rx_waiting <= 1'b0;
		else if (link.rx_packet_done)
			rx_waiting <= 1'b1; // see (R13)
		else if (wr_csr & wd[usbep_pkg::BIT_ACK_RX])
			rx_waiting <= 1'b0; // see (R6)
	end

	// Endpoint-0 pending bit, cleared by writing one
	always_ff @(posedge clk) begin
		if (sys_rst)
			pending <= 1'b0;
		else if (any_evt)
			pending <= 1'b1; // see (R14)
		else if (wr_pend & wd[usbep_pkg::BIT_EP0_PENDING])
			pending <= 1'b0;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	// Single-cycle trigger conditions as named sequences
	sequence s_wr_ack_rx;
		wr_csr && wd[6] && !link.rx_packet_done;
	endsequence
	sequence s_wr_ack_early;
		wr_csr && wd[7] && !early_evt;
	endsequence
	sequence s_bus_first;
		req && !answered;
	endsequence
	sequence s_wr_clear_stall;
		wr_csr && !wd[usbep_pkg::BIT_STALL_SENT] && !link.protocol_stall;
	endsequence
	sequence s_wr_set_tx;
		wr_csr && wd[usbep_pkg::BIT_TX_LOADED];
	endsequence

	// Frame number and selector
	a_frame_low_load: assert property (@(posedge clk) disable iff (sys_rst) // see (R1)
		link.sof_valid |=> frame_count_low == $past(link.sof_frame[7:0]))
		else $error("frame low byte not loaded");
	a_frame_high_load: assert property (@(posedge clk) disable iff (sys_rst) // see (R15)
		link.sof_valid |=> frame_count_high[2:0] == $past(link.sof_frame[10:8]))
		else $error("frame high byte not loaded");
	a_frame_high_zero: assert property (@(posedge clk) disable iff (sys_rst) // see (R15)
		frame_count_high[7:3] == 5'b00000)
		else $error("frame high byte has stray bits");
	a_frame_hold: assert property (@(posedge clk) disable iff (sys_rst) // see (R2)
		!link.sof_valid |=> $stable(frame_count_low) && $stable(frame_count_high))
		else $error("frame bytes changed without sof");
	a_frame_reads: assert property (@(posedge clk) disable iff (sys_rst) // see (R2)
		s_bus_first ##0 (avs_read && sel_low) |=> avs_readdata == {24'h000000, $past(frame_count_low)})
		else $error("frame low byte read wrong");
	a_selector_write: assert property (@(posedge clk) disable iff (sys_rst) // see (R3)
		wr_index |=> endpoint_selector == $past(wd))
		else $error("selector not written");
	a_selector_hold: assert property (@(posedge clk) disable iff (sys_rst) // see (R3)
		!wr_index |=> $stable(endpoint_selector))
		else $error("selector changed without write");
	a_csr_gated_sel: assert property (@(posedge clk) disable iff (sys_rst) // see (R4)
		wr && sel_csr && !ep0_sel |=> $stable(force_stall))
		else $error("status written with nonzero selector");
	a_csr_gated_read: assert property (@(posedge clk) disable iff (sys_rst) // see (R4)
		s_bus_first ##0 (avs_read && sel_csr && !ep0_sel) |=> avs_readdata == 32'h0000_0000)
		else $error("status read with nonzero selector");

	// Endpoint-0 status flags
	a_early_ack_clear: assert property (@(posedge clk) disable iff (sys_rst) // see (R5)
		s_wr_ack_early |=> !early_end)
		else $error("early end not acknowledged");
	a_rx_ack_clear: assert property (@(posedge clk) disable iff (sys_rst) // see (R6)
		s_wr_ack_rx |=> !rx_waiting)
		else $error("received flag not cleared");
	a_stall_out: assert property (@(posedge clk) disable iff (sys_rst) // see (R7)
		wr_csr |=> ctrl.force_stall == $past(wd[usbep_pkg::BIT_FORCE_STALL]))
		else $error("stall not driven to link");
	a_early_set: assert property (@(posedge clk) disable iff (sys_rst) // see (R8)
		link.early_end && !last_data |=> early_end ##0 ctrl.fifo_flush)
		else $error("early end not flagged");
	a_early_refused: assert property (@(posedge clk) disable iff (sys_rst) // see (R8)
		link.early_end && last_data && !early_end |=> !early_end)
		else $error("early end flagged after last data");
	a_flush_block: assert property (@(posedge clk) disable iff (sys_rst) // see (R9)
		ctrl.fifo_flush |-> ctrl.fifo_blocked)
		else $error("flush without block");
	a_flush_single: assert property (@(posedge clk) disable iff (sys_rst) // see (R9)
		!early_evt |=> !ctrl.fifo_flush)
		else $error("flush without early end");
	a_last_data_set: assert property (@(posedge clk) disable iff (sys_rst) // see (R10)
		wr_csr && wd[usbep_pkg::BIT_LAST_DATA] |=> last_data)
		else $error("last data not set");
	a_last_data_clr: assert property (@(posedge clk) disable iff (sys_rst) // see (R10)
		link.transfer_done && !(wr_csr && wd[3]) |=> !last_data)
		else $error("last data not cleared");
	a_stall_sent_set: assert property (@(posedge clk) disable iff (sys_rst) // see (R11)
		link.protocol_stall && !(wr_csr && wd[usbep_pkg::BIT_TX_LOADED]) |=> stall_sent && !tx_loaded)
		else $error("stall sent not set");
	a_stall_sent_clr: assert property (@(posedge clk) disable iff (sys_rst) // see (R11)
		s_wr_clear_stall |=> !stall_sent)
		else $error("stall sent not cleared by zero");
	a_stall_sent_keep: assert property (@(posedge clk) disable iff (sys_rst) // see (R11)
		stall_sent && !(wr_csr && !wd[usbep_pkg::BIT_STALL_SENT]) |=> stall_sent)
		else $error("stall sent lost");
	a_tx_cleared: assert property (@(posedge clk) disable iff (sys_rst) // see (R12)
		link.tx_packet_sent && !(wr_csr && wd[1]) |=> !tx_loaded)
		else $error("tx loaded not cleared");
	a_tx_set: assert property (@(posedge clk) disable iff (sys_rst) // see (R12)
		s_wr_set_tx |=> tx_loaded)
		else $error("tx loaded not set");
	a_rx_set_irq: assert property (@(posedge clk) disable iff (sys_rst) // see (R13)
		link.rx_packet_done |=> rx_waiting && pending)
		else $error("received packet not flagged");
	a_pending_set: assert property (@(posedge clk) disable iff (sys_rst) // see (R14)
		any_evt |=> ep0_pending)
		else $error("pending not set");
	a_pending_clear: assert property (@(posedge clk) disable iff (sys_rst) // see (R14)
		wr_pend && wd[usbep_pkg::BIT_EP0_PENDING] && !any_evt |=> !ep0_pending)
		else $error("pending not cleared");

	// Bus answer timing
	a_bus_wait: assert property (@(posedge clk) disable iff (sys_rst)
		s_bus_first |-> avs_waitrequest ##1 answered)
		else $error("bus answer not after one wait");
	a_bus_idle: assert property (@(posedge clk) disable iff (sys_rst)
		!req |-> !avs_waitrequest)
		else $error("wait raised with no request");
endmodule

/* usbep_link_model.sv */
// Model of the USB link logic: issues one-cycle event pulses on request.
// Assumes the bench calls ev() from its main sequence on the shared clock.
`timescale 1ns/1ps
module usbep_link_model (
	input wire logic clk,
	output usbep_pkg::usbep_link_s link
);
	// ------------------------------------------------------------
	// Event pulses
	// ------------------------------------------------------------
	initial link = '0;

	// Kind 0 frame start, 1 rx, 2 tx sent, 3 stall, 4 early end, 5 done
	task automatic ev(input int k, input logic [10:0] f);
		usbep_pkg::usbep_link_s v;
		v = '0;
		case (k)
			0: begin
				v.sof_valid = 1'b1;
				v.sof_frame = f;
			end
			1: v.rx_packet_done = 1'b1;
			2: v.tx_packet_sent = 1'b1;
			3: v.protocol_stall = 1'b1;
			4: v.early_end = 1'b1;
			default: v.transfer_done = 1'b1;
		endcase
		@(posedge clk);
		link <= v;
		@(posedge clk);
		link <= '0;
		#1;
	endtask
endmodule

/* testbench.sv */
// Self-checking bench for the endpoint-0 register block.
// Assumes one 200 MHz clock and a one-wait Avalon slave.
`timescale 1ns/1ps
module testbench;
	// ------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------
	localparam logic [31:0] FL = usbep_pkg::ADDR_FRAME_LOW;
	localparam logic [31:0] FH = usbep_pkg::ADDR_FRAME_HIGH;
	localparam logic [31:0] SEL = usbep_pkg::ADDR_SELECTOR;
	localparam logic [31:0] ST = usbep_pkg::ADDR_EP0_STATUS;
	localparam logic [31:0] PND = usbep_pkg::ADDR_EP_PENDING;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [31:0] avs_address = '0;
	logic [31:0] avs_writedata = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	usbep_pkg::usbep_link_s link;
	usbep_pkg::usbep_ctrl_s ctrl;
	logic [7:0] endpoint_index;
	logic ep0_pending;
	int error_cnt = 0;
	int n_compared = 0;

	// Clock
	always #2.5 clk = ~clk;

	usbep_regs dut (
		.clk(clk),
		.sys_rst(sys_rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.link(link),
		.ctrl(ctrl),
		.endpoint_index(endpoint_index),
		.ep0_pending(ep0_pending)
	);

	usbep_link_model partner (
		.clk(clk),
		.link(link)
	);

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One bus access, held until waitrequest is seen low
	task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] q);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		avs_read <= ~w;
		avs_write <= w;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// Writes let the falling edge pass so port checks see the new state
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		wr_be(a, d, 4'h1);
	endtask

	task automatic wr_be(input logic [31:0] a, input logic [7:0] d, input logic [3:0] be);
		logic [31:0] q;
		acc(1'b1, a, d, be, q);
		@(negedge clk);
	endtask

	task automatic rd(input string nm, input logic [31:0] a, input logic [7:0] e);
		logic [31:0] q;
		acc(1'b0, a, 8'h00, 4'h1, q);
		chk(nm, {24'h0, e}, q);
	endtask

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		finish_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		rd("frame_low", FL, 8'h00);
		rd("frame_high", FH, 8'h00);
		rd("selector", SEL, 8'h00);
		rd("status", ST, 8'h00);
		partner.ev(0, 11'h5a3);
		rd("frame_low", FL, 8'ha3);
		rd("frame_high", FH, 8'h05);
		wr(FL, 8'hff);
		rd("frame_low", FL, 8'ha3);
		partner.ev(1, 11'h0);
		chk("pending", 32'h1, {31'h0, ep0_pending});
		chk("rx_pin", 32'h1, {31'h0, ctrl.rx_waiting});
		wr(SEL, 8'h03);
		chk("index", 32'h3, {24'h0, endpoint_index});
		rd("status", ST, 8'h00);
		wr(ST, 8'h20);
		chk("stall", 32'h0, {31'h0, ctrl.force_stall});
		wr_be(SEL, 8'h55, 4'h0);
		rd("selector", SEL, 8'h03);
		wr(SEL, 8'h00);
		rd("status", ST, 8'h01);
		wr(PND, 8'h01);
		chk("pending", 32'h0, {31'h0, ep0_pending});
		wr(ST, 8'h60);
		rd("status", ST, 8'h20);
		chk("stall", 32'h1, {31'h0, ctrl.force_stall});
		wr(ST, 8'h00);
		rd("status", ST, 8'h00);
		wr(ST, 8'h0a);
		rd("status", ST, 8'h0a);
		partner.ev(2, 11'h0);
		chk("tx_pin", 32'h0, {31'h0, ctrl.tx_loaded});
		rd("status", ST, 8'h08);
		chk("pending", 32'h1, {31'h0, ep0_pending});
		partner.ev(4, 11'h0);
		rd("status", ST, 8'h08);
		partner.ev(5, 11'h0);
		rd("status", ST, 8'h00);
		partner.ev(4, 11'h0);
		chk("flush", 32'h1, {31'h0, ctrl.fifo_flush});
		chk("blocked", 32'h1, {31'h0, ctrl.fifo_blocked});
		rd("status", ST, 8'h10);
		chk("flush", 32'h0, {31'h0, ctrl.fifo_flush});
		wr(ST, 8'h80);
		rd("status", ST, 8'h00);
		partner.ev(3, 11'h0);
		rd("status", ST, 8'h04);
		wr(ST, 8'h04);
		rd("status", ST, 8'h04);
		wr(ST, 8'h00);
		rd("status", ST, 8'h00);
		// Reset again in mid-run; frame byte and pending must return to zero
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd("frame_low", FL, 8'h00);
		chk("pending", 32'h0, {31'h0, ep0_pending});
		finish_test();
	end
endmodule
